// ---- hw/sacc_pkg.sv ----
package sacc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the AXI4-Lite port
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_SC = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_CLKCFG = 8'h08;
   localparam logic [7:0] ADDR_PORT_DATA = 8'h0C;
   localparam logic [7:0] ADDR_PORT_DIR = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // field layouts
   typedef struct packed {
      logic done;
      logic irqEn;
      logic cont;
      logic [4:0] chan;
   } sacc_sc_t;

   typedef struct packed {
      logic [2:0] div;
      logic src;
   } sacc_clkcfg_t;

   typedef struct packed {
      logic [7:0] ext;
      logic refHigh;
      logic refLow;
      logic powerOff;
   } sacc_mux_t;

   localparam sacc_sc_t SC_RESET = 8'h1F;
   localparam sacc_clkcfg_t CLK_RESET = 4'h0;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam int CLK_FIELD_LSB = 4;

   ////////////////////////////////////////////////////////////////////////
   // channel codes and conversion timing in converter clock ticks
   localparam logic [4:0] CH_EXT_LAST = 5'h07;
   localparam logic [4:0] CH_REF_HIGH = 5'h1D;
   localparam logic [4:0] CH_REF_LOW = 5'h1E;
   localparam logic [4:0] CH_POWER_OFF = 5'h1F;
   localparam logic [4:0] SAMPLE_TICKS = 5'h08;
   localparam logic [4:0] CONV_TICKS = 5'h10;
   localparam logic [7:0] TRIAL_START = 8'h80;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_APPROX = 3'b100
   } sacc_state_t;

endpackage

// ---- hw/sacc_top.sv ----
// Functional notes
// - control register write starts conversion with new settings
// - conversion takes 16 to 17 converter clocks
// - continuous mode overwrites result every conversion
// - continuous conversions repeat until mode bit cleared
// - single mode: one conversion per write
// - flag read-only, set at end; continuous first only
// - control write or result read clears flag
// - interrupts enabled: flag software writable, no completion
// - interrupt raised each end, dropped on read/write
// - reset clears flag, interrupt enable, continuous bit
// - five-bit channel code decoded to inputs, references
// - all-ones channel code powers converter off
// - reserved channel codes give undefined result
// - selected shared pin forced to converter input
// - port read of selected pin returns zero
// - result full scale high ref, zero low ref
// - keeps running in wait, interrupt wakes
// - stop aborts conversion, resumes after stop exit
// - divider field divides by 1,2,4,8 or 16
// - clock source bit selects bus or oscillator
// - result register loaded at every completion
module sacc_top
   import sacc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic oscTick,
   input wire logic stopMode,
   input wire logic compareHigh,
   input wire logic [7:0] portPinIn,
   output logic [7:0] portPinOut,
   output logic [7:0] portPinOe,
   output logic [7:0] trialCode,
   output sacc_mux_t muxSel,
   output logic irqRequest
);

   function automatic sacc_mux_t decodeMux(input logic [4:0] chan);
      sacc_mux_t m;
      m = '0;
      if (chan <= CH_EXT_LAST) begin
         m.ext = 8'h01 << chan[2:0];
      end
      m.refHigh = (chan == CH_REF_HIGH);
      m.refLow = (chan == CH_REF_LOW);
      m.powerOff = (chan == CH_POWER_OFF);
      return m;
   endfunction

   function automatic logic [3:0] divLast(input logic [2:0] d);
      logic [3:0] r;
      r = 4'hF;
      if (!d[2]) begin
         r = 4'((5'h01 << d[1:0]) - 5'h01);
      end
      return r;
   endfunction

   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic wStrb0_reg;
   sacc_sc_t sc_reg;
   sacc_clkcfg_t clkCfg_reg;
   logic [7:0] portData_reg, portDir_reg;
   logic [7:0] pinOut_reg, pinOe_reg;
   sacc_mux_t mux_reg;
   logic irq_reg, armed_reg, runWanted_reg;
   logic [3:0] divCnt_reg;
   logic convTick_reg, convDone_reg;
   sacc_state_t state_reg;
   logic [4:0] phase_reg;
   logic [7:0] trial_reg, result_reg;
   logic [4:0] asrtTicks_reg;

   logic doWrite, wrMapped, scWrite, dataRead, setDone, finishing;
   logic srcTick;
   logic [2:0] bitIdx;
   logic [7:0] decided, nextTrial, selMask;
   sacc_sc_t wSc;
   sacc_mux_t selMux;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign doWrite = !awready_reg && !wready_reg && !bvalid_reg;
   assign wrMapped = (awAddr_reg == ADDR_SC) || (awAddr_reg == ADDR_CLKCFG)
      || (awAddr_reg == ADDR_PORT_DATA) || (awAddr_reg == ADDR_PORT_DIR);
   // a write without the low byte lane carries no register data
   assign scWrite = doWrite && wStrb0_reg && (awAddr_reg == ADDR_SC);
   assign wSc = sacc_sc_t'(wData_reg[7:0]);
   assign dataRead = s_axi_arvalid && arready_reg
      && (s_axi_araddr == ADDR_DATA);

   always_ff @(posedge clk) begin
      if (reset) begin
         awready_reg <= 1'b1;
         awAddr_reg <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         awAddr_reg <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wready_reg <= 1'b1;
         wData_reg <= '0;
         wStrb0_reg <= 1'b0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         wData_reg <= s_axi_wdata;
         wStrb0_reg <= s_axi_wstrb[0];
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
         case (s_axi_araddr)
            ADDR_SC: rdata_reg[7:0] <= sc_reg;
            ADDR_DATA: rdata_reg[7:0] <= result_reg;
            ADDR_CLKCFG: rdata_reg[7:CLK_FIELD_LSB] <= clkCfg_reg;
            ADDR_PORT_DATA: begin
               // the pin owned by the converter reads as zero
               rdata_reg[7:0] <= ((portDir_reg & portData_reg)
                  | (~portDir_reg & portPinIn)) & ~selMask;
            end
            ADDR_PORT_DIR: rdata_reg[7:0] <= portDir_reg;
            default: rresp_reg <= RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status/control register, flag and interrupt request
   assign setDone = convDone_reg && !sc_reg.irqEn && armed_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         sc_reg <= SC_RESET;
      end else begin
         if (scWrite) begin
            sc_reg.chan <= wSc.chan;
            sc_reg.cont <= wSc.cont;
            sc_reg.irqEn <= wSc.irqEn;
            // flag is only software writable with interrupts on
            sc_reg.done <= (wSc.irqEn && wSc.done) || setDone;
         end else if (setDone) begin
            sc_reg.done <= 1'b1;
         end else if (dataRead) begin
            sc_reg.done <= 1'b0;
         end
      end
   end

   // a later completion in continuous mode no longer sets the flag
   always_ff @(posedge clk) begin
      if (reset) begin
         armed_reg <= 1'b0;
      end else if (scWrite) begin
         armed_reg <= 1'b1;
      end else if (convDone_reg) begin
         armed_reg <= 1'b0;
      end
   end

   // request also serves as the wake source in wait mode
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else if (convDone_reg && sc_reg.irqEn) begin
         irq_reg <= 1'b1;
      end else if (dataRead || scWrite) begin
         irq_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock configuration and port registers
   always_ff @(posedge clk) begin
      if (reset) begin
         clkCfg_reg <= CLK_RESET;
         portData_reg <= PORT_RESET;
         portDir_reg <= PORT_RESET;
      end else if (doWrite && wStrb0_reg) begin
         case (awAddr_reg)
            ADDR_CLKCFG: clkCfg_reg <= wData_reg[7:CLK_FIELD_LSB];
            ADDR_PORT_DATA: portData_reg <= wData_reg[7:0];
            ADDR_PORT_DIR: portDir_reg <= wData_reg[7:0];
            default: ;
         endcase
      end
   end

   assign selMux = decodeMux(sc_reg.chan);
   assign selMask = selMux.ext;

   always_ff @(posedge clk) begin
      if (reset) begin
         pinOut_reg <= PORT_RESET;
         pinOe_reg <= PORT_RESET;
         mux_reg <= decodeMux(SC_RESET.chan);
      end else begin
         pinOut_reg <= portData_reg & ~selMask;
         pinOe_reg <= portDir_reg & ~selMask;
         mux_reg <= decodeMux(sc_reg.chan);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // converter clock divider
   assign srcTick = clkCfg_reg.src ? 1'b1 : oscTick;

   // compare with >= so that shrinking the ratio never stalls the count
   always_ff @(posedge clk) begin
      if (reset) begin
         divCnt_reg <= '0;
         convTick_reg <= 1'b0;
      end else begin
         convTick_reg <= 1'b0;
         if (srcTick) begin
            if (divCnt_reg >= divLast(clkCfg_reg.div)) begin
               divCnt_reg <= '0;
               convTick_reg <= 1'b1;
            end else begin
               divCnt_reg <= divCnt_reg + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // successive approximation sequencer
   // bit under test follows the phase because sampling spans 8 ticks
   assign bitIdx = ~phase_reg[2:0];
   assign decided = trial_reg & ~({7'h00, !compareHigh} << bitIdx);
   assign nextTrial = decided | (8'(8'h01 << bitIdx) >> 1);
   assign finishing = (state_reg == ST_APPROX) && convTick_reg
      && (phase_reg == CONV_TICKS - 5'h01) && !stopMode && !scWrite;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         phase_reg <= '0;
         trial_reg <= '0;
      end else if (stopMode || scWrite) begin
         state_reg <= ST_IDLE;
         phase_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (runWanted_reg) begin
                  state_reg <= ST_SAMPLE;
                  phase_reg <= '0;
               end
            end
            ST_SAMPLE: begin
               if (convTick_reg) begin
                  phase_reg <= phase_reg + 5'h01;
                  if (phase_reg == SAMPLE_TICKS - 5'h01) begin
                     state_reg <= ST_APPROX;
                     trial_reg <= TRIAL_START;
                  end
               end
            end
            ST_APPROX: begin
               if (convTick_reg) begin
                  phase_reg <= phase_reg + 5'h01;
                  trial_reg <= nextTrial;
                  if (finishing) begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // reserved codes still run; the result is whatever the mux delivers
   always_ff @(posedge clk) begin
      if (reset) begin
         result_reg <= '0;
         convDone_reg <= 1'b0;
      end else begin
         convDone_reg <= finishing;
         if (finishing) begin
            result_reg <= decided;
         end
      end
   end

   // stop leaves the request standing so conversions resume afterwards
   always_ff @(posedge clk) begin
      if (reset) begin
         runWanted_reg <= 1'b0;
      end else if (scWrite) begin
         runWanted_reg <= (wSc.chan != CH_POWER_OFF);
      end else if (finishing && !sc_reg.cont) begin
         runWanted_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_reg == ST_IDLE) begin
         asrtTicks_reg <= '0;
      end else if (convTick_reg) begin
         asrtTicks_reg <= asrtTicks_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign portPinOut = pinOut_reg;
   assign portPinOe = pinOe_reg;
   assign trialCode = trial_reg;
   assign muxSel = mux_reg;
   assign irqRequest = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   conv_len_a: assert property (@(posedge clk) disable iff (reset)
      convDone_reg |-> $past(asrtTicks_reg) == 5'h0F)
      else $error("conversion did not take sixteen ticks");

   result_load_a: assert property (@(posedge clk) disable iff (reset)
      $changed(result_reg) |-> convDone_reg)
      else $error("result changed outside a completion");

   flag_clear_a: assert property (@(posedge clk) disable iff (reset)
      dataRead && !setDone && !scWrite |=> !sc_reg.done)
      else $error("flag not cleared by result read");

   irq_set_a: assert property (@(posedge clk) disable iff (reset)
      convDone_reg && sc_reg.irqEn |=> irqRequest [*1] ##0 !sc_reg.done
         || $past(scWrite))
      else $error("no interrupt after completion");

   irq_drop_a: assert property (@(posedge clk) disable iff (reset)
      (dataRead || scWrite) && !convDone_reg |=> !irqRequest)
      else $error("interrupt not dropped");

   single_idle_a: assert property (@(posedge clk) disable iff (reset)
      convDone_reg && !sc_reg.cont && !scWrite ##1 !scWrite [*2]
         |-> state_reg == ST_IDLE)
      else $error("single mode started another conversion");

   cont_repeat_a: assert property (@(posedge clk) disable iff (reset)
      convDone_reg && sc_reg.cont && !scWrite ##1 !stopMode && !scWrite
         |=> state_reg == ST_SAMPLE)
      else $error("continuous mode did not repeat");

   write_restart_a: assert property (@(posedge clk) disable iff (reset)
      scWrite && wSc.chan != CH_POWER_OFF ##1 !stopMode && !scWrite
         |=> state_reg == ST_SAMPLE && phase_reg == 5'h00)
      else $error("write did not restart conversion");

   stop_abort_a: assert property (@(posedge clk) disable iff (reset)
      stopMode |=> state_reg == ST_IDLE && !convDone_reg)
      else $error("conversion ran in stop mode");

   pin_take_a: assert property (@(posedge clk) disable iff (reset)
      sc_reg.chan <= CH_EXT_LAST |=>
         !portPinOe[$past(sc_reg.chan[2:0])])
      else $error("selected pin still driven by port");

   power_off_a: assert property (@(posedge clk) disable iff (reset)
      scWrite && wSc.chan == CH_POWER_OFF |=> ##1 muxSel.powerOff
         && state_reg == ST_IDLE)
      else $error("power-off code not honoured");

endmodule

// ---- tb/sacc_analog_model.sv ----
module sacc_analog_model
   import sacc_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] trialCode,
   input wire sacc_mux_t muxSel,
   input wire logic [7:0] portPinOut,
   input wire logic [7:0] portPinOe,
   input wire logic [63:0] extLevel,
   input wire logic [7:0] pinDrive,
   output logic compareHigh,
   output logic [7:0] portPinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] vin;
   logic noiseReg = 1'b0;
   // no input routed: the comparator wanders, so the result is undefined
   always @(posedge clk) noiseReg <= ~noiseReg;
   always_comb begin
      vin = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (muxSel.ext[i]) vin = extLevel[i*8 +: 8];
      end
      if (muxSel.refHigh) vin = 8'hFF;
      if (muxSel.refLow) vin = 8'h00;
   end
   assign compareHigh = (muxSel[10:1] == 10'h000) ? noiseReg :
      (vin >= trialCode);
   assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & pinDrive);
endmodule

// ---- tb/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sacc_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid;
   logic bready = 1'b0, arvalid = 1'b0, arready, rvalid, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, br, rr;
   logic oscTick = 1'b0, stopMode = 1'b0, compareHigh, irqRequest;
   logic [1:0] oscCnt = 2'h0;
   logic [7:0] portPinIn, portPinOut, portPinOe, trialCode;
   logic [7:0] pinDrive = 8'hFF;
   logic [63:0] extLevel = 64'h7565554535251505;
   sacc_mux_t muxSel;
   int err_total = 0;
   int n_tests = 0;
   always #12.5 clk = ~clk;
   // oscillator clock at a quarter of the bus clock
   always @(posedge clk) begin
      oscCnt <= oscCnt + 2'h1;
      oscTick <= (oscCnt == 2'h3);
   end
   sacc_top i_sacc_top (.clk(clk), .reset(reset),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .oscTick(oscTick), .stopMode(stopMode),
      .compareHigh(compareHigh), .portPinIn(portPinIn),
      .portPinOut(portPinOut), .portPinOe(portPinOe),
      .trialCode(trialCode), .muxSel(muxSel), .irqRequest(irqRequest));
   sacc_analog_model i_sacc_analog_model (.clk(clk),
      .trialCode(trialCode), .muxSel(muxSel), .portPinOut(portPinOut),
      .portPinOe(portPinOe), .extLevel(extLevel), .pinDrive(pinDrive),
      .compareHigh(compareHigh), .portPinIn(portPinIn));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w;
      int n;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h0, d};
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1 && n < 100);
      br = bresp;
      bready <= 1'b0;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      if (n >= 100) chk("write answer", 1, 0);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
      arvalid <= 1'b0;
      if (n >= 100) chk("read answer", 1, 0);
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      while (irqRequest !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      do begin
         rd(ADDR_SC);
         n++;
      end while (rv[7] !== 1'b1 && n < 100);
      chk("done flag", 1, rv[7]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(ADDR_SC);
      chk("sc reset", 32'h1F, rv);
      rd(ADDR_CLKCFG);
      chk("clk reset", 32'h0, rv);
      chk("irq reset", 0, irqRequest);
      chk("power off", 1, muxSel.powerOff);
   endtask
   task automatic t_single();
      logic [4:0] codes [4] = '{5'h03, 5'h1D, 5'h1E, 5'h07};
      logic [7:0] exps [4] = '{8'h35, 8'hFF, 8'h00, 8'h75};
      wr(ADDR_CLKCFG, 8'h10);
      // first result after power-off is thrown away while analog settles
      wr(ADDR_SC, 8'h03);
      wait_flag();
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SC, {3'h0, codes[i]});
         wait_flag();
         rd(ADDR_DATA);
         chk("result", exps[i], rv);
         repeat (60) @(posedge clk);
         rd(ADDR_SC);
         chk("flag cleared", {27'h0, codes[i]}, rv);
      end
   endtask
   task automatic t_cont();
      wr(ADDR_SC, 8'h25);
      wait_flag();
      rd(ADDR_DATA);
      chk("cont first", 32'h55, rv);
      extLevel[47:40] <= 8'h9A;
      repeat (120) @(posedge clk);
      rd(ADDR_DATA);
      chk("cont next", 32'h9A, rv);
      extLevel[47:40] <= 8'h3C;
      repeat (120) @(posedge clk);
      rd(ADDR_DATA);
      chk("cont again", 32'h3C, rv);
      wr(ADDR_SC, 8'h1F);
      // the mux output follows the written channel one clock later
      repeat (2) @(posedge clk);
      chk("powered off", 1, muxSel.powerOff);
      extLevel[47:40] <= 8'h11;
      repeat (120) @(posedge clk);
      rd(ADDR_DATA);
      chk("cont stopped", 32'h3C, rv);
   endtask
   task automatic t_irq();
      int n;
      wr(ADDR_SC, 8'h42);
      wait_irq(n);
      chk("irq raised", 1, irqRequest);
      rd(ADDR_SC);
      chk("flag no done", 32'h42, rv);
      rd(ADDR_DATA);
      chk("irq result", 32'h25, rv);
      repeat (2) @(posedge clk);
      chk("irq read drop", 0, irqRequest);
      wr(ADDR_SC, 8'h42);
      wait_irq(n);
      wr(ADDR_SC, 8'h42);
      chk("irq write drop", 0, irqRequest);
      repeat (10) @(posedge clk);
      wr(ADDR_SC, 8'h43);
      wait_irq(n);
      rd(ADDR_DATA);
      chk("restart chan", 32'h35, rv);
   endtask
   task automatic t_div();
      logic [3:0] cfg [7] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hF, 4'h0};
      int r [7] = '{1, 2, 4, 8, 16, 16, 4};
      int n;
      for (int i = 0; i < 7; i++) begin
         wr(ADDR_CLKCFG, {cfg[i], 4'h0});
         wr(ADDR_SC, 8'h41);
         wait_irq(n);
         // one tick of slack for the divider phase at the start
         chk("conv time", 1, n >= 15 * r[i] && n <= 17 * r[i] + 4);
      end
      rd(ADDR_DATA);
   endtask
   task automatic t_stop();
      int n;
      wr(ADDR_CLKCFG, 8'h10);
      wr(ADDR_SC, 8'h41);
      repeat (10) @(posedge clk);
      stopMode <= 1'b1;
      repeat (200) @(posedge clk);
      chk("stop idle", 0, irqRequest);
      stopMode <= 1'b0;
      wait_irq(n);
      chk("stop resume", 1, n >= 16 && n <= 22);
      rd(ADDR_DATA);
      chk("stop result", 32'h15, rv);
   endtask
   task automatic t_port();
      wr(ADDR_SC, 8'h02);
      wr(ADDR_PORT_DIR, 8'h00);
      rd(ADDR_PORT_DATA);
      chk("pin read", 32'hFB, rv);
      wr(ADDR_PORT_DIR, 8'hFF);
      wr(ADDR_PORT_DATA, 8'hFF);
      repeat (2) @(posedge clk);
      chk("pin oe", 8'hFB, portPinOe);
      chk("pin out", 8'hFB, portPinOut);
      rd(ADDR_PORT_DATA);
      chk("latch read", 32'hFB, rv);
      wr(ADDR_SC, 8'h04);
      repeat (2) @(posedge clk);
      chk("pin oe moved", 8'hEF, portPinOe);
      rd(8'h14);
      chk("unmapped resp", RESP_SLVERR, rr);
      chk("unmapped data", 32'h0, rv);
      wr(8'h14, 8'hFF);
      chk("unmapped wr", RESP_SLVERR, br);
      // a write without the low byte lane must leave the register alone
      wstrb <= 4'h0;
      wr(ADDR_PORT_DIR, 8'h00);
      wstrb <= 4'hF;
      chk("strobe off resp", RESP_OKAY, br);
      rd(ADDR_PORT_DIR);
      chk("strobe off data", 32'hFF, rv);
   endtask
   task automatic t_rst_mid();
      wr(ADDR_SC, 8'hE5);
      rd(ADDR_SC);
      chk("flag writable", 32'hE5, rv);
      // reset lands before the conversion just started can complete
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_SC);
      chk("sc mid reset", 32'h1F, rv);
      rd(ADDR_CLKCFG);
      chk("clk mid reset", 32'h0, rv);
      chk("irq mid reset", 0, irqRequest);
      chk("off mid reset", 1, muxSel.powerOff);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_single();
      t_cont();
      t_irq();
      t_div();
      t_stop();
      t_rst_mid();
      t_port();
      results();
   end
   // the whole sequence needs well under 20k cycles
   initial begin
      #2000000;
      err_total++;
      results();
   end
endmodule
